// >>> hw/nvma_top.sv
// register access to the external eeprom and the fuse shadow registers
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
`include "nvma_cfg.svh"

module nvma_top
    import nvma_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic [9:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    output nvma_ee_req_t              ee_req_o,
    input  wire nvma_ee_rsp_t         ee_rsp_i,
    input  wire logic                 nvm_detected_i,
    output nvma_fuse_req_t            fuse_req_o,
    input  wire logic [2:0]           state_machine_trace_i,
    input  wire logic                 sec_event_i,
    input  wire logic [15:0]          sig_upper_bits_i,
    input  wire logic [7:0]           sig_lower_bits_i,
    input  wire logic                 shadow_load_i,
    input  wire logic [15:0]          shadow_load_data_i,
    output logic                      irq_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    nvma_ee_state_t ee_state,     next_ee_state;
    nvma_ee_req_t   ee_req,       next_ee_req;
    logic           ee_err,       next_ee_err;
    logic [7:0]     ee_rbyte,     next_ee_rbyte;
    logic [15:0]    sig_high,     next_sig_high;
    logic [7:0]     sig_low,      next_sig_low;
    logic [15:0]    shadow_word,  next_shadow_word;
    logic [4:0]     shadow_addr,  next_shadow_addr;
    logic           sec_flag,     next_sec_flag;
    logic [2:0]     sm_trace,     next_sm_trace;
    logic           sm_cmd_wr,    next_sm_cmd_wr;
    logic [2:0]     sm_cmd,       next_sm_cmd;
    logic [2:0]     irq_status,   next_irq_status;
    logic [2:0]     irq_mask,     next_irq_mask;
    logic           ack,          next_ack;
    logic [31:0]    rdata,        next_rdata;
    logic [2:0]     det_sync,     next_det_sync;
    logic           detected,     next_detected;

    logic        req;
    logic        wr_go;
    logic [7:0]  idx;
    logic [15:0] wd;
    logic [1:0]  be;
    logic [15:0] rd_word;
    logic        ee_done;

    // ------------------------------------------------------------------
    // bus slave: one wait cycle, answer at the second edge
    // ------------------------------------------------------------------
    assign req               = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack;
    assign wr_go             = avs_write_i & ~ack;
    assign idx               = avs_address_i[9:2];
    assign wd                = avs_writedata_i[15:0];
    assign be                = avs_byteenable_i[1:0];
    assign avs_readdata_o    = rdata;
    assign ee_done           = (ee_state == NVMA_EE_BUSY) & ee_rsp_i.done;

    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  lanes);
        merge16 = {lanes[1] ? new_v[15:8] : old_v[15:8],
                   lanes[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = 16'h0000;
        case (idx)
            // reserved space reads zero and ignores writes
            `NVMA_IDX_RESERVED:    rd_word = 16'h0000;
            `NVMA_IDX_EE_CMD: begin
                rd_word = {(ee_state == NVMA_EE_BUSY), ee_err, detected,
                           5'h00, ee_rbyte};
            end
            `NVMA_IDX_SIG_HIGH:    rd_word = sig_high;
            `NVMA_IDX_SIG_LOW:     rd_word = {sig_low, 8'h00};
            `NVMA_IDX_SHADOW_DATA: rd_word = shadow_word;
            `NVMA_IDX_SHADOW_CTRL: begin
                rd_word = {sec_flag, 2'b00, shadow_addr, 5'h00, sm_trace};
            end
            `NVMA_IDX_IRQ_STATUS:  rd_word = {13'h0000, irq_status};
            `NVMA_IDX_IRQ_MASK:    rd_word = {13'h0000, irq_mask};
            default:               rd_word = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------
    // next-state logic for the whole register group
    // ------------------------------------------------------------------
    always_comb begin
        next_ack         = req & ~ack;
        next_rdata       = rdata;
        next_ee_state    = ee_state;
        next_ee_req      = ee_req;
        next_ee_req.start = 1'b0;
        next_ee_err      = ee_err;
        next_ee_rbyte    = ee_rbyte;
        next_sig_high    = sig_upper_bits_i;
        next_sig_low     = sig_lower_bits_i;
        next_shadow_word = shadow_word;
        next_shadow_addr = shadow_addr;
        next_sec_flag    = sec_flag;
        next_sm_trace    = state_machine_trace_i;
        next_sm_cmd_wr   = 1'b0;
        next_sm_cmd      = sm_cmd;
        next_irq_status  = irq_status;
        next_irq_mask    = irq_mask;
        // detection pin: accept a change once stages two and three agree
        next_det_sync    = {det_sync[1:0], nvm_detected_i};
        next_detected    = (det_sync[1] == det_sync[2]) ? det_sync[2] : detected;

        if (avs_read_i & ~ack) begin
            next_rdata = {16'h0000, rd_word};
        end

        if (wr_go) begin
            case (idx)
                `NVMA_IDX_EE_CMD: begin
                    // a command while busy is dropped; software must poll first
                    if (ee_state == NVMA_EE_IDLE && be == 2'b11) begin
                        next_ee_req.start = 1'b1;
                        next_ee_req.read  = wd[`NVMA_EE_DIR_BIT];
                        next_ee_req.addr  = wd[`NVMA_EE_ADDR_HI:`NVMA_EE_ADDR_LO];
                        next_ee_req.wdata = wd[7:0];
                        next_ee_state     = NVMA_EE_BUSY;
                    end
                end
                `NVMA_IDX_SHADOW_DATA: begin
                    next_shadow_word = merge16(shadow_word, wd, be);
                end
                `NVMA_IDX_SHADOW_CTRL: begin
                    if (be[1]) begin
                        next_shadow_addr = wd[`NVMA_SC_ADDR_HI:`NVMA_SC_ADDR_LO];
                        if (!wd[`NVMA_SC_SEC_BIT]) begin
                            next_sec_flag = 1'b0;
                        end
                    end
                    // unlock bit must be set in the same write as the command
                    if (be[0] && wd[`NVMA_SC_UNLOCK_BIT]) begin
                        next_sm_cmd    = wd[2:0];
                        next_sm_cmd_wr = 1'b1;
                    end
                end
                `NVMA_IDX_IRQ_STATUS: begin
                    if (be[0]) begin
                        next_irq_status = irq_status & ~wd[2:0];
                    end
                end
                `NVMA_IDX_IRQ_MASK: begin
                    if (be[0]) begin
                        next_irq_mask = wd[2:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // the fuse array reloading the shadow word overrides a bus write
        if (shadow_load_i) begin
            next_shadow_word = shadow_load_data_i;
        end

        case (ee_state)
            NVMA_EE_IDLE: begin
            end
            NVMA_EE_BUSY: begin
                if (ee_rsp_i.done) begin
                    next_ee_state = NVMA_EE_IDLE;
                    next_ee_err   = ee_rsp_i.err;
                    if (ee_req.read) begin
                        next_ee_rbyte = ee_rsp_i.rdata;
                    end
                end
            end
            default: next_ee_state = NVMA_EE_IDLE;
        endcase

        // hardware sets win over same-cycle clears
        if (sec_event_i) begin
            next_sec_flag = 1'b1;
        end
        if (ee_done) begin
            next_irq_status[`NVMA_IRQ_EE_DONE] = 1'b1;
        end
        if (ee_done & ee_rsp_i.err) begin
            next_irq_status[`NVMA_IRQ_EE_ERR] = 1'b1;
        end
        if (sec_event_i) begin
            next_irq_status[`NVMA_IRQ_SEC] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // bus answer registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack         <= 1'b0;
            rdata       <= 32'h00000000;
        end else begin
            ack         <= next_ack;
            rdata       <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // eeprom access registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ee_state    <= NVMA_EE_IDLE;
            ee_req      <= '0;
            ee_err      <= 1'b0;
            ee_rbyte    <= 8'h00;
        end else begin
            ee_state    <= next_ee_state;
            ee_req      <= next_ee_req;
            ee_err      <= next_ee_err;
            ee_rbyte    <= next_ee_rbyte;
        end
    end

    // ------------------------------------------------------------------
    // fuse shadow and signature registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sig_high    <= `NVMA_RST16;
            sig_low     <= 8'h00;
            shadow_word <= `NVMA_RST16;
            shadow_addr <= 5'h00;
            sec_flag    <= 1'b0;
            sm_trace    <= `NVMA_RST3;
            sm_cmd_wr   <= 1'b0;
            sm_cmd      <= `NVMA_RST3;
        end else begin
            sig_high    <= next_sig_high;
            sig_low     <= next_sig_low;
            shadow_word <= next_shadow_word;
            shadow_addr <= next_shadow_addr;
            sec_flag    <= next_sec_flag;
            sm_trace    <= next_sm_trace;
            sm_cmd_wr   <= next_sm_cmd_wr;
            sm_cmd      <= next_sm_cmd;
        end
    end

    // ------------------------------------------------------------------
    // interrupt and detect pin registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_status  <= 3'h0;
            irq_mask    <= 3'h0;
            det_sync    <= 3'h0;
            detected    <= 1'b0;
        end else begin
            irq_status  <= next_irq_status;
            irq_mask    <= next_irq_mask;
            // stage one may go metastable, so only stage two reads it
            det_sync    <= next_det_sync;
            detected    <= next_detected;
        end
    end

    // ------------------------------------------------------------------
    // outputs toward the eeprom engine and the fuse array
    // ------------------------------------------------------------------
    assign ee_req_o = ee_req;
    assign irq_o    = |(irq_status & irq_mask);

    always_comb begin
        fuse_req_o.cmd_wr     = sm_cmd_wr;
        fuse_req_o.cmd        = sm_cmd;
        fuse_req_o.addr       = shadow_addr;
        fuse_req_o.sig_word   = (shadow_addr == `NVMA_BANK_SIG_LOW) ||
                                (shadow_addr == `NVMA_BANK_SIG_HIGH);
        fuse_req_o.trace_word = (shadow_addr >= `NVMA_BANK_TRACE_FIRST) &&
                                (shadow_addr <= `NVMA_BANK_TRACE_LAST);
        // signature bits are forced into their bank words on the way out
        case (shadow_addr)
            `NVMA_BANK_SIG_LOW:  fuse_req_o.wdata = {sig_low, shadow_word[7:0]};
            `NVMA_BANK_SIG_HIGH: fuse_req_o.wdata = sig_high;
            default:             fuse_req_o.wdata = shadow_word;
        endcase
    end

endmodule // nvma_top

// >>> hw/nvma_cfg.svh
// offsets, field positions, reset values and fuse bank layout for the nvm access block
`ifndef NVMA_CFG_SVH
`define NVMA_CFG_SVH

// ----------------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------------
`define NVMA_IDX_RESERVED      8'h00
`define NVMA_IDX_EE_CMD        8'h6c
`define NVMA_IDX_SIG_HIGH      8'h6d
`define NVMA_IDX_SIG_LOW       8'h6e
`define NVMA_IDX_SHADOW_DATA   8'h6f
`define NVMA_IDX_SHADOW_CTRL   8'h70
`define NVMA_IDX_IRQ_STATUS    8'h80
`define NVMA_IDX_IRQ_MASK      8'h81

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define NVMA_EE_DIR_BIT        15
`define NVMA_EE_BUSY_BIT       15
`define NVMA_EE_ERR_BIT        14
`define NVMA_EE_DET_BIT        13
`define NVMA_EE_ADDR_HI        14
`define NVMA_EE_ADDR_LO        8
`define NVMA_SC_SEC_BIT        15
`define NVMA_SC_ADDR_HI        12
`define NVMA_SC_ADDR_LO        8
`define NVMA_SC_UNLOCK_BIT     3
`define NVMA_IRQ_EE_DONE       0
`define NVMA_IRQ_EE_ERR        1
`define NVMA_IRQ_SEC           2

// ----------------------------------------------------------------------
// reset values and fuse bank layout
// ----------------------------------------------------------------------
`define NVMA_RST16             16'h0000
`define NVMA_RST3              3'h0
`define NVMA_BANK_SIG_LOW      5'h0e
`define NVMA_BANK_SIG_HIGH     5'h0f
`define NVMA_BANK_TRACE_FIRST  5'h10
`define NVMA_BANK_TRACE_LAST   5'h12

`endif

// >>> hw/nvma_pkg.sv
// types shared by the nvm access block
package nvma_pkg;

    typedef enum logic [1:0] {
        NVMA_EE_IDLE = 2'b01,
        NVMA_EE_BUSY = 2'b10
    } nvma_ee_state_t;

    typedef struct packed {
        logic       start;
        logic       read;
        logic [6:0] addr;
        logic [7:0] wdata;
    } nvma_ee_req_t;

    typedef struct packed {
        logic       done;
        logic       err;
        logic [7:0] rdata;
    } nvma_ee_rsp_t;

    typedef struct packed {
        logic        cmd_wr;
        logic [2:0]  cmd;
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        sig_word;
        logic        trace_word;
    } nvma_fuse_req_t;

endpackage

// >>> dv/nvma_top_props.sv
// assertions on the ports of the nvm access block
`timescale 1ns/10ps
`include "nvma_cfg.svh"

module nvma_top_props
    import nvma_pkg::*;
(
    input wire logic           clk_i,
    input wire logic           arst_n_i,
    input wire logic [9:0]     avs_address_i,
    input wire logic           avs_read_i,
    input wire logic           avs_write_i,
    input wire logic [31:0]    avs_writedata_i,
    input wire logic [31:0]    avs_readdata_o,
    input wire logic           avs_waitrequest_o,
    input wire nvma_ee_req_t   ee_req_o,
    input wire nvma_fuse_req_t fuse_req_o
);
    // ----------------------------------------
    // decoded bus phases
    // ----------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic [7:0] idx;
    logic       rd_ok;
    logic       fw;
    assign idx   = avs_address_i[9:2];
    assign rd_ok = avs_read_i && !avs_waitrequest_o;
    // first cycle of a control write, the one the block acts on
    assign fw    = avs_write_i && avs_waitrequest_o && idx == `NVMA_IDX_SHADOW_CTRL;
    property p_ack; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer late");
    property p_src; ee_req_o.start |-> $past(avs_write_i) && $past(idx) == `NVMA_IDX_EE_CMD;
    endproperty
    a_src: assert property (p_src) else $error("access start without command");
    property p_fld; ee_req_o.start |-> ee_req_o[15:0] == $past(avs_writedata_i[15:0]);
    endproperty
    a_fld: assert property (p_fld) else $error("access fields differ");
    property p_pulse; ee_req_o.start |=> !ee_req_o.start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("start held");
    property p_fcmd; fuse_req_o.cmd_wr |-> $past(fw) && $past(avs_writedata_i[3:0]) == {1'b1, fuse_req_o.cmd};
    endproperty
    a_fcmd: assert property (p_fcmd) else $error("fuse command wrong");
    property p_lock; fw && !avs_writedata_i[3] |=> !fuse_req_o.cmd_wr;
    endproperty
    a_lock: assert property (p_lock) else $error("locked command passed");
    property p_cmdz; rd_ok && idx == `NVMA_IDX_EE_CMD |-> avs_readdata_o[31:8] == {16'h0000, avs_readdata_o[15:13], 5'h00};
    endproperty
    a_cmdz: assert property (p_cmdz) else $error("command read zero bits set");
    property p_sigz; rd_ok && idx == `NVMA_IDX_SIG_LOW |-> avs_readdata_o[7:0] == 8'h00;
    endproperty
    a_sigz: assert property (p_sigz) else $error("signature low byte set");
    c_start: cover property (ee_req_o.start);
    c_fcmd: cover property (fuse_req_o.cmd_wr);
    c_sig: cover property (rd_ok && idx == `NVMA_IDX_SIG_HIGH);
endmodule // nvma_top_props

bind nvma_top nvma_top_props nvma_top_props_i (
    .clk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .ee_req_o, .fuse_req_o
);

// >>> dv/nvma_eeprom_model.sv
// behavioural eeprom answering the block's access requests
`timescale 1ns/10ps

module nvma_eeprom_model
    import nvma_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire nvma_ee_req_t req_i,
    input  wire logic [3:0]   lat_i,
    input  wire logic         fail_i,
    output nvma_ee_rsp_t      rsp_o
);
    logic [7:0] mem [128];
    logic [3:0] cnt;
    logic       act;
    // ----------------------------------------
    // access engine
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt   <= 4'h0;
            act   <= 1'b0;
            rsp_o <= '0;
        end else begin
            // outside done the lines invert every cycle, so they carry the last answer again on every second cycle
            rsp_o <= {1'b0, ~rsp_o.err, ~rsp_o.rdata};
            if (req_i.start) begin
                act <= 1'b1;
                cnt <= lat_i;
            end else if (act && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (act) begin
                act   <= 1'b0;
                rsp_o <= {1'b1, fail_i, req_i.read ? mem[req_i.addr] : ~rsp_o.rdata};
                // a failed write leaves the cell untouched
                if (!req_i.read && !fail_i) mem[req_i.addr] <= req_i.wdata;
            end
        end
    end
endmodule // nvma_eeprom_model

// >>> dv/test_nvma_top.sv
// self-checking bench for the nvm access block
`timescale 1ns/10ps

module test_nvma_top
    import nvma_pkg::*;
;
    logic           clk_i = 1'b0;
    logic           arst_n_i = 1'b0;
    logic [9:0]     avs_address_i = 10'h000;
    logic           avs_read_i = 1'b0;
    logic           avs_write_i = 1'b0;
    logic [31:0]    avs_writedata_i = 32'h0;
    logic [3:0]     avs_byteenable_i = 4'h3;
    logic [31:0]    avs_readdata_o;
    logic           avs_waitrequest_o;
    nvma_ee_req_t   ee_req_o;
    nvma_ee_rsp_t   ee_rsp_i;
    logic           nvm_detected_i = 1'b0;
    nvma_fuse_req_t fuse_req_o;
    logic [2:0]     state_machine_trace_i = 3'h0;
    logic           sec_event_i = 1'b0;
    logic [15:0]    sig_upper_bits_i = 16'h0;
    logic [7:0]     sig_lower_bits_i = 8'h0;
    logic           shadow_load_i = 1'b0;
    logic [15:0]    shadow_load_data_i = 16'h0000;
    logic           irq_o;
    logic [3:0]     lat = 4'h8;
    logic           fail = 1'b0;
    logic [31:0]    q;
    logic [7:0]     rst_idx [8] = '{8'h00, 8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h80, 8'h81};
    int             failures = 0;
    int             num_checks = 0;
    always #10 clk_i = ~clk_i;
    nvma_top nvma_top_i (
        .clk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .ee_req_o, .ee_rsp_i,
        .nvm_detected_i, .fuse_req_o, .state_machine_trace_i, .sec_event_i,
        .sig_upper_bits_i, .sig_lower_bits_i, .shadow_load_i,
        .shadow_load_data_i, .irq_o
    );
    nvma_eeprom_model nvma_eeprom_model_i (
        .clk_i, .arst_n_i, .req_i(ee_req_o), .lat_i(lat), .fail_i(fail), .rsp_o(ee_rsp_i)
    );
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic results();
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
            failures++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        avs_read_i      <= ~w;
        avs_write_i     <= w;
        avs_address_i   <= {a, 2'b00};
        avs_writedata_i <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        // one idle edge so the next request never reassigns in this step
        @(posedge clk_i);
        if (n >= 20) begin
            failures++;
            results();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(q[15:0], e);
    endtask
    task automatic idle(input logic [15:0] e);
        int n;
        n = 0;
        do begin
            bus(1'b0, 8'h6c, 16'h0000);
            n++;
        end while (q[15] !== 1'b0 && n < 40);
        if (n >= 40) begin
            failures++;
            results();
        end
        chk(q[15:0], e);
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (rst_idx[i]) rd(rst_idx[i], 16'h0000);
        sig_upper_bits_i <= 16'hc3a5;
        sig_lower_bits_i <= 8'h96;
        nvm_detected_i   <= 1'b1;
        bus(1'b1, 8'h6d, 16'hffff);
        bus(1'b1, 8'h00, 16'hffff);
        rd(8'h6d, 16'hc3a5);
        rd(8'h6e, 16'h9600);
        rd(8'h00, 16'h0000);
        bus(1'b1, 8'h81, 16'h0007);
        bus(1'b1, 8'h6c, 16'h2a5c);
        rd(8'h6c, 16'ha000);
        idle(16'h2000);
        chk({15'h0000, irq_o}, 16'h0001);
        bus(1'b1, 8'h80, 16'h0001);
        chk({15'h0000, irq_o}, 16'h0000);
        lat <= 4'h1;
        bus(1'b1, 8'h6c, 16'haa00);
        idle(16'h205c);
        fail <= 1'b1;
        bus(1'b1, 8'h6c, 16'h2a11);
        idle(16'h605c);
        rd(8'h80, 16'h0003);
        fail <= 1'b0;
        avs_byteenable_i <= 4'h1;
        bus(1'b1, 8'h6c, 16'haa00);
        rd(8'h6c, 16'h605c);
        avs_byteenable_i <= 4'h3;
        bus(1'b1, 8'h6c, 16'haa00);
        idle(16'h205c);
        state_machine_trace_i <= 3'h6;
        bus(1'b1, 8'h70, 16'h0b0d);
        chk({8'h00, fuse_req_o.addr, fuse_req_o.cmd}, 16'h005d);
        bus(1'b1, 8'h70, 16'h0b02);
        chk({8'h00, fuse_req_o.addr, fuse_req_o.cmd}, 16'h005d);
        rd(8'h70, 16'h0b06);
        sec_event_i <= 1'b1;
        @(posedge clk_i);
        sec_event_i <= 1'b0;
        rd(8'h70, 16'h8b06);
        bus(1'b1, 8'h70, 16'h8b00);
        rd(8'h70, 16'h8b06);
        bus(1'b1, 8'h80, 16'h0003);
        bus(1'b1, 8'h81, 16'h0003);
        chk({15'h0000, irq_o}, 16'h0000);
        bus(1'b1, 8'h81, 16'h0004);
        chk({15'h0000, irq_o}, 16'h0001);
        bus(1'b1, 8'h70, 16'h0b00);
        rd(8'h70, 16'h0b06);
        bus(1'b1, 8'h6f, 16'h1234);
        rd(8'h6f, 16'h1234);
        bus(1'b1, 8'h70, 16'h0e00);
        chk(fuse_req_o.wdata, 16'h9634);
        chk({15'h0000, fuse_req_o.sig_word}, 16'h0001);
        bus(1'b1, 8'h70, 16'h0f00);
        chk(fuse_req_o.wdata, 16'hc3a5);
        bus(1'b1, 8'h70, 16'h1200);
        chk({15'h0000, fuse_req_o.trace_word}, 16'h0001);
        chk({15'h0000, fuse_req_o.sig_word}, 16'h0000);
        bus(1'b1, 8'h70, 16'h1300);
        chk({15'h0000, fuse_req_o.trace_word}, 16'h0000);
        shadow_load_i      <= 1'b1;
        shadow_load_data_i <= 16'h5aa5;
        @(posedge clk_i);
        shadow_load_i      <= 1'b0;
        rd(8'h6f, 16'h5aa5);
        results();
    end
endmodule // test_nvma_top
